// >>> bench/ibsw_isa_host.sv
// isa host model that runs memory and port cycles on the bus
`timescale 1ns/1ps
module ibsw_isa_host (
   input wire logic pclk,
   input wire logic [7:0] bus_in,
   input wire logic dev_oe_n,
   output logic [19:0] isa_addr,
   output logic [7:0] host_data,
   output logic host_oe_n,
   output logic [3:0] strb_n
);
   initial begin
      isa_addr = '0;
      host_data = '0;
      host_oe_n = 1'b1;
      strb_n = 4'hF;
   end
   // ********
   // bus cycle
   // ********
   // k: 0 mem read, 1 mem write, 2 port read, 3 port write; data sampled late in the strobe
   // bank number is written to the port like any port write
   task automatic cyc(input int k, input logic [19:0] a, input logic [7:0] d, output logic [7:0] r,
                      output logic seen);
      seen = 1'b0;
      isa_addr <= a;
      host_data <= d;
      host_oe_n <= ~k[0];
      @(posedge pclk);
      strb_n[k] <= 1'b0;
      repeat (12) begin
         @(posedge pclk);
         seen |= (dev_oe_n === 1'b0);
      end
      r = bus_in;
      strb_n <= 4'hF;
      // data held past the strobe so the device's synchronised copy stays good
      repeat (4) @(posedge pclk);
      host_oe_n <= 1'b1;
      @(posedge pclk);
   endtask : cyc
endmodule : ibsw_isa_host

// >>> bench/test_isa_banked_sram_window.sv
// self-checking bench for the banked sram window controller
`timescale 1ns/1ps
module test_isa_banked_sram_window;
   typedef struct packed {
      logic [1:0] k;
      logic [19:0] a;
      logic [7:0] d;
      logic [7:0] e;
      logic s;
   } ibsw_row_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, s, er;
   logic [7:0] paddr, isa_data_out, sram_dq_out, host_data, isa_bus, sram_bus, last_isa, last_sram, r;
   logic [31:0] pwdata, prdata, rd;
   logic [19:0] isa_addr;
   logic [18:0] sram_addr;
   logic [3:0] strb_n;
   logic isa_data_oe_n, host_oe_n, sram_ce_n, sram_oe_n, sram_we_n, sram_dq_oe_n;
   logic window_base_sel_lo, window_base_sel_hi, io_base_sel_bit0, io_base_sel_bit1, io_base_sel_bit2;
   logic io_base_sel_bit3, sram_access_enable_input;
   logic [7:0] mem [524288];
   int miscompares = 0;
   int n_tests = 0;
   int n_cyc = 0;
   ibsw_row_s rows [12] = '{
      '{2'd3, 20'h0_0200, 8'hE3, 8'h00, 1'b0}, '{2'd2, 20'h0_0200, 8'h00, 8'h03, 1'b1},
      '{2'd1, 20'hD_0010, 8'h55, 8'h00, 1'b0}, '{2'd0, 20'hD_0010, 8'h00, 8'h55, 1'b1},
      '{2'd3, 20'h0_0200, 8'h04, 8'h00, 1'b0}, '{2'd1, 20'hD_3FFF, 8'hAA, 8'h00, 1'b0},
      '{2'd3, 20'h0_0200, 8'h03, 8'h00, 1'b0}, '{2'd0, 20'hD_3FFF, 8'h00, 8'h00, 1'b1},
      '{2'd3, 20'h0_0200, 8'h04, 8'h00, 1'b0}, '{2'd0, 20'hD_3FFF, 8'h00, 8'hAA, 1'b1},
      '{2'd0, 20'hD_4000, 8'h00, 8'h00, 1'b0}, '{2'd0, 20'hC_FFFF, 8'h00, 8'h00, 1'b0}};
   logic [19:0] bases [4] = '{20'hD_0000, 20'hD_4000, 20'hD_8000, 20'hD_C000};
   logic [9:0] ports [10] = '{10'h200, 10'h214, 10'h2A4, 10'h2F4, 10'h2C0, 10'h2C4, 10'h2D0, 10'h2D4,
                              10'h2E0, 10'h2E4};
   logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA};
   localparam logic [3:0] LO_V = 4'h6;
   localparam logic [3:0] HI_V = 4'hA;
   // ********
   // design and far side
   // ********
   always #5 pclk = ~pclk;
   // released lines show the inverse of their last level, never a stale copy
   assign isa_bus = !isa_data_oe_n ? isa_data_out : !host_oe_n ? host_data : ~last_isa;
   assign sram_bus = (!sram_ce_n && !sram_oe_n) ? mem[sram_addr] : !sram_dq_oe_n ? sram_dq_out : ~last_sram;
   always @(posedge pclk) begin
      last_isa <= isa_bus;
      last_sram <= sram_bus;
   end
   always @(posedge sram_we_n) if (!sram_ce_n) mem[sram_addr] <= sram_bus;
   always @(posedge pclk) begin
      n_cyc++;
      if (n_cyc == 5000) begin
         miscompares++;
         report_and_stop();
      end
   end
   ibsw_top i_dut (
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .isa_addr,
      .isa_data_in(isa_bus), .isa_data_out, .isa_data_oe_n, .isa_memr_n(strb_n[0]), .isa_memw_n(strb_n[1]),
      .isa_ior_n(strb_n[2]), .isa_iow_n(strb_n[3]), .isa_aen(1'b0), .window_base_sel_lo, .window_base_sel_hi,
      .io_base_sel_bit0, .io_base_sel_bit1, .io_base_sel_bit2, .io_base_sel_bit3, .sram_access_enable_input,
      .sram_addr, .sram_ce_n, .sram_oe_n, .sram_we_n, .sram_dq_in(sram_bus), .sram_dq_out, .sram_dq_oe_n
   );
   ibsw_isa_host i_host (.pclk, .bus_in(isa_bus), .dev_oe_n(isa_data_oe_n), .isa_addr, .host_data,
                         .host_oe_n, .strb_n);
   // ********
   // tasks
   // ********
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk(32'(pready), 1, "apb answer");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic settle();
      repeat (4) @(posedge pclk);
   endtask : settle
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   // ********
   // tests
   // ********
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {window_base_sel_lo, window_base_sel_hi, io_base_sel_bit3, io_base_sel_bit2} = '0;
      {io_base_sel_bit1, io_base_sel_bit0} = '0;
      sram_access_enable_input = 1'b1;
      last_isa = '0;
      last_sram = '0;
      for (int i = 0; i < 524288; i++) mem[i] = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({sram_ce_n, sram_oe_n, sram_we_n, sram_dq_oe_n, isa_data_oe_n, pready}, 6'h3E, "idle");
      apb(1'b0, 8'h00, '0);
      chk(rd, 1, "ctrl reset");
      apb(1'b0, 8'h04, '0);
      chk(rd, 0, "bank reset");
      apb(1'b1, 8'h10, 32'h0000_00FF);
      chk(er, 1, "unmapped write");
      apb(1'b0, 8'h10, '0);
      chk({er, rd[7:0]}, 9'h100, "unmapped read");
      $display("done: reset");
      foreach (rows[i]) begin
         i_host.cyc(int'(rows[i].k), rows[i].a, rows[i].d, r, s);
         chk(s, rows[i].s, "device drives bus");
         if (rows[i].s) chk(r, rows[i].e, "read data");
      end
      chk(mem[19'h1_3FFF], 8'hAA, "bank 4 top byte");
      chk(mem[19'h0_C010], 8'h55, "bank 3 byte");
      $display("done: rows");
      for (int i = 0; i < 4; i++) begin
         window_base_sel_lo <= LO_V[i];
         window_base_sel_hi <= HI_V[i];
         settle();
         i_host.cyc(1, bases[i] + 20'h0_0123, 8'h60 | 8'(i), r, s);
         i_host.cyc(0, bases[i] + 20'h0_0123, 8'h00, r, s);
         chk(r, 8'h60 | 8'(i), "window data");
         i_host.cyc(0, bases[i] + 20'h0_4000, 8'h00, r, s);
         chk(s, 0, "above window");
      end
      $display("done: window bases");
      for (int i = 0; i < 10; i++) begin
         {io_base_sel_bit3, io_base_sel_bit2, io_base_sel_bit1, io_base_sel_bit0} <= codes[i];
         settle();
         i_host.cyc(3, {10'h000, ports[i]}, 8'hE0 | 8'(i), r, s);
         i_host.cyc(2, {10'h000, ports[i]}, 8'h00, r, s);
         chk({s, r}, {1'b1, 8'(i)}, "port reads bank");
         i_host.cyc(2, {10'h000, ports[(i + 9) % 10]}, 8'h00, r, s);
         chk(s, 0, "old port silent");
      end
      $display("done: port bases");
      sram_access_enable_input <= 1'b0;
      settle();
      i_host.cyc(3, 20'h0_02E4, 8'h1F, r, s);
      i_host.cyc(2, 20'h0_02E4, 8'h00, r, s);
      chk(s, 0, "port off");
      i_host.cyc(1, 20'hD_C200, 8'h77, r, s);
      chk(mem[19'h2_4200], 8'h00, "write off");
      i_host.cyc(0, 20'hD_C123, 8'h00, r, s);
      chk(s, 0, "window off");
      sram_access_enable_input <= 1'b1;
      settle();
      i_host.cyc(2, 20'h0_02E4, 8'h00, r, s);
      chk({s, r}, 9'h109, "bank kept");
      i_host.cyc(0, 20'hD_C123, 8'h00, r, s);
      chk(s, 1, "window back");
      $display("done: enable strap");
      // fourteen window accesses ran while enabled: five rows, eight in the base loop, one after the strap came back
      apb(1'b0, 8'h0C, '0);
      chk(rd, 32'h0000_000E, "access count");
      apb(1'b0, 8'h08, '0);
      chk(rd, 32'h0000_01AB, "status straps");
      apb(1'b1, 8'h00, '0);
      i_host.cyc(0, 20'hD_C123, 8'h00, r, s);
      chk(s, 0, "soft disable");
      apb(1'b1, 8'h00, 32'h0000_0001);
      apb(1'b0, 8'h00, '0);
      chk(rd, 1, "soft enable back");
      apb(1'b0, 8'h04, '0);
      chk(rd, 9, "bank via apb");
      apb(1'b1, 8'h04, 32'h0000_0035);
      i_host.cyc(2, 20'h0_02E4, 8'h00, r, s);
      chk({s, r}, 9'h115, "apb bank write");
      $display("done: apb registers");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 8'h04, '0);
      chk(rd, 0, "bank after reset");
      $display("done: second reset");
      report_and_stop();
   end
endmodule : test_isa_banked_sram_window

// >>> logic/ibsw_pkg.sv
// constants and types shared by the banked sram window controller
// ****************************************
// ****************************************
package ibsw_pkg;
   localparam int BANK_W = 5;
   localparam int OFS_W = 14;
   localparam int SRAM_AW = BANK_W + OFS_W;
   // apb register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] BANK_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] CNT_OFS = 8'h0C;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam logic [BANK_W-1:0] BANK_RST = 5'h00;
   localparam logic [15:0] CNT_RST = 16'h0000;
   // isa address bits 19:14 of the window at select code 0 (D0000)
   localparam logic [5:0] SEG_BASE = 6'h34;
   // port bases indexed by strap code; bit set in the mask marks a listed code
   localparam logic [15:0] IO_VALID_MASK = 16'h05FF;
   localparam logic [9:0] IO_TAB [16] = '{10'h200, 10'h214, 10'h2A4, 10'h2F4, 10'h2C0, 10'h2C4, 10'h2D0,
                                          10'h2D4, 10'h2E0, 10'h000, 10'h2E4, 10'h000, 10'h000, 10'h000,
                                          10'h000, 10'h000};
   // synchroniser reset: strobes and aen idle high, all else low
   localparam int SYNC_W = 48;
   localparam logic [SYNC_W-1:0] SYNC_RST = 48'h0000_0000_0F80;

   typedef struct packed {
      logic io_ok;
      logic [9:0] io_base;
      logic [5:0] win_seg;
   } ibsw_cfg_s;
   localparam ibsw_cfg_s CFG_RST = '{io_ok: 1'b0, io_base: 10'h000, win_seg: 6'h34};

   typedef enum {ST_IDLE, ST_MRD, ST_MWR, ST_IORD, ST_IOWR, ST_REL} ibsw_state_e;
endpackage : ibsw_pkg

// >>> logic/ibsw_strap_dec.sv
// decodes the switch straps into window segment and port base
`timescale 1ns/1ps
module ibsw_strap_dec (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic base_lo,
   input wire logic base_hi,
   input wire logic [3:0] io_sel,
   output ibsw_pkg::ibsw_cfg_s cfg_q
);
   ibsw_pkg::ibsw_cfg_s cfg_d;

   always_comb begin
      cfg_d = cfg_q;
      cfg_d.win_seg = ibsw_pkg::SEG_BASE + {4'h0, base_lo ^ base_hi, base_hi};
      cfg_d.io_base = ibsw_pkg::IO_TAB[io_sel];
      // reserved codes leave the port unmapped
      cfg_d.io_ok = ibsw_pkg::IO_VALID_MASK[io_sel];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= ibsw_pkg::CFG_RST;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   win_d800_a: assert property ($past(base_lo) && !$past(base_hi) |-> cfg_q.win_seg == 6'h36)
      else $error("window base not D800 for select H,L");
   io_2e4_a: assert property ($past(io_sel) == 4'hA |-> cfg_q.io_ok && cfg_q.io_base == 10'h2E4)
      else $error("port base not 2E4 for code 1010");
   io_resv_a: assert property ($past(io_sel) == 4'h9 |-> !cfg_q.io_ok)
      else $error("reserved port code was mapped");
endmodule : ibsw_strap_dec

// >>> logic/ibsw_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ibsw_sync #(
   parameter int W = 8,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : ibsw_sync

// >>> logic/ibsw_top.sv
// isa banked sram window controller with apb status and control
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module ibsw_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [19:0] isa_addr,
   input wire logic [7:0] isa_data_in,
   output logic [7:0] isa_data_out,
   output logic isa_data_oe_n,
   input wire logic isa_memr_n,
   input wire logic isa_memw_n,
   input wire logic isa_ior_n,
   input wire logic isa_iow_n,
   input wire logic isa_aen,
   input wire logic window_base_sel_lo,
   input wire logic window_base_sel_hi,
   input wire logic io_base_sel_bit0,
   input wire logic io_base_sel_bit1,
   input wire logic io_base_sel_bit2,
   input wire logic io_base_sel_bit3,
   input wire logic sram_access_enable_input,
   output logic [18:0] sram_addr,
   output logic sram_ce_n,
   output logic sram_oe_n,
   output logic sram_we_n,
   input wire logic [7:0] sram_dq_in,
   output logic [7:0] sram_dq_out,
   output logic sram_dq_oe_n
);
   // ****************************************
   // pin synchronisers and strap decode
   // ****************************************
   logic [19:0] addr_s;
   logic [7:0] data_s;
   logic [7:0] sdq_s;
   logic memr_s, memw_s, ior_s, iow_s, aen_s;
   logic base_lo_s, base_hi_s, strap_en_s;
   logic [3:0] io_sel_s;
   ibsw_pkg::ibsw_cfg_s cfg;

   ibsw_sync #(
      .W(ibsw_pkg::SYNC_W),
      .RST_VAL(ibsw_pkg::SYNC_RST)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({isa_addr, isa_data_in, sram_dq_in, isa_memr_n, isa_memw_n, isa_ior_n, isa_iow_n, isa_aen,
          window_base_sel_lo, window_base_sel_hi, io_base_sel_bit3, io_base_sel_bit2, io_base_sel_bit1,
          io_base_sel_bit0, sram_access_enable_input}),
      .q({addr_s, data_s, sdq_s, memr_s, memw_s, ior_s, iow_s, aen_s,
          base_lo_s, base_hi_s, io_sel_s, strap_en_s})
   );

   ibsw_strap_dec u_dec (
      .pclk(pclk),
      .presetn(presetn),
      .base_lo(base_lo_s),
      .base_hi(base_hi_s),
      .io_sel(io_sel_s),
      .cfg_q(cfg)
   );

   // ****************************************
   // state and registers
   // ****************************************
   ibsw_pkg::ibsw_state_e state_q, state_d;
   logic [ibsw_pkg::BANK_W-1:0] bank_q, bank_d;
   logic [18:0] sram_addr_q, sram_addr_d;
   logic sram_ce_n_q, sram_ce_n_d, sram_oe_n_q, sram_oe_n_d, sram_we_n_q, sram_we_n_d;
   logic [7:0] sram_dq_out_q, sram_dq_out_d;
   logic sram_dq_oe_n_q, sram_dq_oe_n_d;
   logic [7:0] isa_data_out_q, isa_data_out_d;
   logic isa_data_oe_n_q, isa_data_oe_n_d;
   logic [15:0] cnt_q, cnt_d;
   logic ctrl_en_q, ctrl_en_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;

   logic en, mem_hit, io_hit, apb_wr, apb_acc;

   // high strap enables; software can only further gate it
   assign en = strap_en_s & ctrl_en_q;
   // aen high marks a dma cycle, which never belongs to this window
   assign mem_hit = !aen_s && (addr_s[19:14] == cfg.win_seg);
   assign io_hit = !aen_s && cfg.io_ok && (addr_s[9:0] == cfg.io_base);
   assign apb_acc = psel & penable;
   assign apb_wr = apb_acc & pready_q & pwrite;

   // ****************************************
   // isa cycle engine
   // ****************************************
   always_comb begin
      state_d = state_q;
      bank_d = bank_q;
      sram_addr_d = sram_addr_q;
      sram_ce_n_d = sram_ce_n_q;
      sram_oe_n_d = sram_oe_n_q;
      sram_we_n_d = sram_we_n_q;
      sram_dq_out_d = sram_dq_out_q;
      sram_dq_oe_n_d = sram_dq_oe_n_q;
      isa_data_out_d = isa_data_out_q;
      isa_data_oe_n_d = isa_data_oe_n_q;
      cnt_d = cnt_q;
      unique case (state_q)
         ibsw_pkg::ST_IDLE: begin
            sram_ce_n_d = 1'b1;
            sram_oe_n_d = 1'b1;
            sram_we_n_d = 1'b1;
            sram_dq_oe_n_d = 1'b1;
            isa_data_oe_n_d = 1'b1;
            // nothing starts while access is disabled
            if (en) begin
               if (!memr_s && mem_hit) begin
                  state_d = ibsw_pkg::ST_MRD;
                  // bank picks one 16KB slice of the sram
                  sram_addr_d = {bank_q, addr_s[ibsw_pkg::OFS_W-1:0]};
                  sram_ce_n_d = 1'b0;
                  sram_oe_n_d = 1'b0;
                  isa_data_oe_n_d = 1'b0;
                  cnt_d = cnt_q + 16'h0001;
               end else if (!memw_s && mem_hit) begin
                  state_d = ibsw_pkg::ST_MWR;
                  sram_addr_d = {bank_q, addr_s[ibsw_pkg::OFS_W-1:0]};
                  sram_ce_n_d = 1'b0;
                  sram_we_n_d = 1'b0;
                  sram_dq_out_d = data_s;
                  sram_dq_oe_n_d = 1'b0;
                  cnt_d = cnt_q + 16'h0001;
               end else if (!ior_s && io_hit) begin
                  state_d = ibsw_pkg::ST_IORD;
                  isa_data_out_d = {3'h0, bank_q};
                  isa_data_oe_n_d = 1'b0;
               end else if (!iow_s && io_hit) begin
                  state_d = ibsw_pkg::ST_IOWR;
                  // latch low five bits of the port write
                  bank_d = data_s[ibsw_pkg::BANK_W-1:0];
               end
            end
            // software bank write yields to a starting isa cycle, so address and bank agree
            if (apb_wr && paddr == ibsw_pkg::BANK_OFS && state_d == ibsw_pkg::ST_IDLE) begin
               bank_d = pwdata[ibsw_pkg::BANK_W-1:0];
            end
         end
         ibsw_pkg::ST_MRD: begin
            isa_data_out_d = sdq_s;
            if (memr_s) begin
               state_d = ibsw_pkg::ST_REL;
               sram_ce_n_d = 1'b1;
               sram_oe_n_d = 1'b1;
               isa_data_oe_n_d = 1'b1;
            end
         end
         ibsw_pkg::ST_MWR: begin
            sram_dq_out_d = data_s;
            // we rises first, data held one more cycle for hold time
            if (memw_s) begin
               state_d = ibsw_pkg::ST_REL;
               sram_we_n_d = 1'b1;
            end
         end
         ibsw_pkg::ST_IORD: begin
            if (ior_s) begin
               state_d = ibsw_pkg::ST_REL;
               isa_data_oe_n_d = 1'b1;
            end
         end
         ibsw_pkg::ST_IOWR: begin
            if (iow_s) begin
               state_d = ibsw_pkg::ST_REL;
            end
         end
         ibsw_pkg::ST_REL: begin
            state_d = ibsw_pkg::ST_IDLE;
            sram_ce_n_d = 1'b1;
            sram_dq_oe_n_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ibsw_pkg::ST_IDLE;
         bank_q <= ibsw_pkg::BANK_RST;
         sram_addr_q <= 19'h0_0000;
         sram_ce_n_q <= 1'b1;
         sram_oe_n_q <= 1'b1;
         sram_we_n_q <= 1'b1;
         sram_dq_out_q <= 8'h00;
         sram_dq_oe_n_q <= 1'b1;
         isa_data_out_q <= 8'h00;
         isa_data_oe_n_q <= 1'b1;
         cnt_q <= ibsw_pkg::CNT_RST;
      end else begin
         state_q <= state_d;
         bank_q <= bank_d;
         sram_addr_q <= sram_addr_d;
         sram_ce_n_q <= sram_ce_n_d;
         sram_oe_n_q <= sram_oe_n_d;
         sram_we_n_q <= sram_we_n_d;
         sram_dq_out_q <= sram_dq_out_d;
         sram_dq_oe_n_q <= sram_dq_oe_n_d;
         isa_data_out_q <= isa_data_out_d;
         isa_data_oe_n_q <= isa_data_oe_n_d;
         cnt_q <= cnt_d;
      end
   end

   // ****************************************
   // apb slave
   // ****************************************
   // one wait state: read data is prepared in the first access cycle
   always_comb begin
      ctrl_en_d = ctrl_en_q;
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      pready_d = apb_acc & !pready_q;
      if (apb_acc && !pready_q) begin
         prdata_d = 32'h0000_0000;
         unique case (paddr)
            ibsw_pkg::CTRL_OFS: prdata_d = {31'h0000_0000, ctrl_en_q};
            ibsw_pkg::BANK_OFS: prdata_d = {27'h000_0000, bank_q};
            ibsw_pkg::STAT_OFS: prdata_d = {22'h00_0000, state_q != ibsw_pkg::ST_IDLE, cfg.io_ok, io_sel_s,
                                            base_hi_s, base_lo_s, en, strap_en_s};
            ibsw_pkg::CNT_OFS: prdata_d = {16'h0000, cnt_q};
            default: pslverr_d = 1'b1;
         endcase
      end
      if (apb_wr && paddr == ibsw_pkg::CTRL_OFS) begin
         ctrl_en_d = pwdata[0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_en_q <= ibsw_pkg::CTRL_EN_RST;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         ctrl_en_q <= ctrl_en_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign isa_data_out = isa_data_out_q;
   assign isa_data_oe_n = isa_data_oe_n_q;
   assign sram_addr = sram_addr_q;
   assign sram_ce_n = sram_ce_n_q;
   assign sram_oe_n = sram_oe_n_q;
   assign sram_we_n = sram_we_n_q;
   assign sram_dq_out = sram_dq_out_q;
   assign sram_dq_oe_n = sram_dq_oe_n_q;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   strap_open_a: assert property ((state_q == ibsw_pkg::ST_IDLE) && strap_en_s && ctrl_en_q
                                  && !memr_s && mem_hit
                                  |=> (state_q == ibsw_pkg::ST_MRD) && !sram_oe_n_q && !sram_ce_n_q)
      else $error("enabled window read did not start");
   disabled_idle_a: assert property ((state_q == ibsw_pkg::ST_IDLE) && !en
                                     |=> (state_q == ibsw_pkg::ST_IDLE) && sram_ce_n_q)
      else $error("cycle started while access disabled");
   bank_slice_a: assert property (!sram_ce_n_q |-> sram_addr_q[18:14] == bank_q)
      else $error("sram access outside selected bank");
   bank_latch_a: assert property ((state_q == ibsw_pkg::ST_IOWR) && ($past(state_q) == ibsw_pkg::ST_IDLE)
                                  |-> bank_q == $past(data_s[4:0]))
      else $error("port write did not latch bank");
   offset_pass_a: assert property ((state_q == ibsw_pkg::ST_IDLE) ##1 (state_q == ibsw_pkg::ST_MWR)
                                   |-> sram_addr_q[13:0] == $past(addr_s[13:0]))
      else $error("window offset not passed to sram");
   read_drive_a: assert property ((state_q == ibsw_pkg::ST_MRD) |-> !isa_data_oe_n_q && sram_we_n_q)
      else $error("window read not driving isa data");
   release_idle_a: assert property ((state_q == ibsw_pkg::ST_REL)
                                    |=> (state_q == ibsw_pkg::ST_IDLE) && sram_ce_n_q && sram_dq_oe_n_q)
      else $error("release did not return to idle");
   // we rises a cycle before chip enable and the data driver let go
   write_hold_a: assert property ((state_q == ibsw_pkg::ST_MWR) && memw_s
                                  |=> sram_we_n_q && !sram_ce_n_q && !sram_dq_oe_n_q)
      else $error("write data not held past write strobe");
   apb_wait_a: assert property (apb_acc && !pready_q |=> pready_q ##1 !pready_q)
      else $error("apb answer not after one wait state");

   mem_read_c: cover property ((state_q == ibsw_pkg::ST_IDLE) ##1 (state_q == ibsw_pkg::ST_MRD));
   mem_write_c: cover property ((state_q == ibsw_pkg::ST_MWR) ##1 (state_q == ibsw_pkg::ST_REL));
   port_write_c: cover property ((state_q == ibsw_pkg::ST_IOWR) ##[1:20] (state_q == ibsw_pkg::ST_IDLE));
   port_read_c: cover property ((state_q == ibsw_pkg::ST_IORD) ##1 !isa_data_oe_n_q);
   apb_error_c: cover property (pready_q && pslverr_q);
endmodule : ibsw_top
